// [rtl/rcbr_pkg.sv]
// Package for the reset-cause and boot-remap block: offsets, fields,
// reset values, timing constants and boot sequencer states.
// Assumes a single 200 MHz core clock.
package rcbr_pkg;

    // ========================================================
    // Clock and timing
    // ========================================================
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RST_HOLD_NS = 100;
    localparam int RST_HOLD_CYCLES = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int KERNEL_CYCLES = 64;

    // ========================================================
    // Memory map
    // ========================================================
    localparam logic [31:0] VEC_BASE = 32'h0000_0000;
    localparam logic [31:0] VEC_TOP = 32'h0000_0020;
    localparam logic [31:0] MIRROR_SIZE = 32'h0000_0800;
    localparam logic [31:0] FLASH_BASE = 32'h0008_0000;
    localparam logic [31:0] SRAM_BASE = 32'h0001_0000;
    localparam logic [31:0] KERNEL_BASE = 32'h0009_F800;
    localparam logic [31:0] KERNEL_SIZE = 32'h0000_0800;

    // ========================================================
    // Register offsets (byte addresses)
    // ========================================================
    localparam logic [7:0] OFS_MAP_SEL = 8'h00;
    localparam logic [7:0] OFS_CAUSE = 8'h04;
    localparam logic [7:0] OFS_CAUSE_CLR = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
    localparam logic [7:0] OFS_BOOT_STAT = 8'h18;

    // ========================================================
    // Fields and reset values
    // ========================================================
    localparam int MAP_SRAM_BIT = 0;
    localparam int CAUSE_POR_BIT = 0;
    localparam int CAUSE_WDT_BIT = 1;
    localparam int CAUSE_SW_BIT = 2;
    localparam logic [2:0] CAUSE_RESET = 3'h1;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam int IRQ_DENIED_BIT = 0;
    localparam int IRQ_BADCLR_BIT = 1;
    localparam int IRQ_BOOTED_BIT = 2;

    // ========================================================
    // Boot sequencer states
    // ========================================================
    typedef enum logic [1:0] {
        BOOT_HOLD = 2'b00,
        BOOT_KERNEL = 2'b01,
        BOOT_RUN = 2'b10,
        BOOT_LOADER = 2'b11
    } rcbr_boot_t;

endpackage

// [rtl/rcbr_sync.sv]
// Two-flop synchroniser for asynchronous pins.
// Assumes the caller reads only the output.
`timescale 1ns/1ps
module rcbr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Data
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stage1_r <= INIT;
            syncOut <= INIT;
        end else begin
            stage1_r <= asyncIn;
            syncOut <= stage1_r;
        end
    end
endmodule

// [rtl/rcbr_top.sv]
// Reset-cause recorder, boot sequencer and low-memory remap.
// Assumes an Avalon-MM master on core_clk, a core that fetches vectors
// through the remapped address port, and a watchdog pulse on core_clk.
`timescale 1ns/1ps
module rcbr_top
    import rcbr_pkg::*;
#(
    parameter int HOLD_CYCLES = RST_HOLD_CYCLES,
    parameter int BOOT_CYCLES = KERNEL_CYCLES
) (
    // Clock and power-on reset
    input wire logic core_clk,
    input wire logic reset,
    // Pins
    input wire logic extResetPinN,
    input wire logic bootModePin,
    // Watchdog, same clock
    input wire logic wdtTimeout,
    // Avalon-MM slave
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    // Core side
    output logic coreResetOut,
    output logic kernelMode,
    output logic [31:0] bootVector,
    input wire logic cpuReq,
    input wire logic [31:0] cpuAddr,
    output logic memReq,
    output logic [31:0] memAddr,
    output logic memSelSram,
    output logic memDenied,
    output logic memVector,
    // Interrupt
    output logic irqOut
);
    // ========================================================
    // Pin synchronisers
    // ========================================================
    logic extResetSyncN;
    logic bootModeSync;

    rcbr_sync #(.WIDTH(2), .INIT(2'b11)) pinSync (
        .core_clk(core_clk),
        .reset(reset),
        .asyncIn({extResetPinN, bootModePin}),
        .syncOut({extResetSyncN, bootModeSync})
    );

    // ========================================================
    // Register bus decode
    // ========================================================
    logic ackPending_r;
    logic [2:0] cause_r;
    logic [2:0] cause_nxt;
    logic mapSram_r;
    logic [2:0] irqStat_r;
    logic [2:0] irqStat_nxt;
    logic [2:0] irqEn_r;
    rcbr_boot_t boot_r;
    rcbr_boot_t boot_nxt;

    wire access = avsRead | avsWrite;
    wire busTake = access & ackPending_r;
    wire laneZero = avsByteEnable[0];
    wire wrTake = busTake & avsWrite & laneZero;
    wire wrMap = wrTake & (avsAddress == OFS_MAP_SEL);
    wire wrCause = wrTake & (avsAddress == OFS_CAUSE);
    wire wrCauseClr = wrTake & (avsAddress == OFS_CAUSE_CLR);
    wire wrIrqEn = wrTake & (avsAddress == OFS_IRQ_EN);
    wire wrIrqClr = wrTake & (avsAddress == OFS_IRQ_CLR);
    wire [2:0] clrBits = avsWriteData[2:0];

    // One wait cycle; the answer comes at the second edge
    assign avsWaitRequest = access & ~ackPending_r;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ackPending_r <= 1'b0;
        end else begin
            ackPending_r <= access & ~ackPending_r;
        end
    end

    // reserved bits read zero, unmapped reads zero
    logic [31:0] readMux;
    assign readMux = (avsAddress == OFS_MAP_SEL) ? {31'h0, mapSram_r} :
                     (avsAddress == OFS_CAUSE) ? {29'h0, cause_r} :
                     (avsAddress == OFS_IRQ_STAT) ? {29'h0, irqStat_r} :
                     (avsAddress == OFS_IRQ_EN) ? {29'h0, irqEn_r} :
                     (avsAddress == OFS_BOOT_STAT) ? {29'h0, bootModeSync, boot_r} :
                     32'h0;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            avsReadData <= 32'h0;
        end else if (avsRead & ~ackPending_r) begin
            avsReadData <= readMux;
        end
    end

    // ========================================================
    // Reset sources
    // ========================================================
    // partial clear leaves a set flag behind
    wire badClear = wrCauseClr & ((cause_r & ~clrBits) != 3'h0);
    // software force by writing bit 2
    wire swForce = wrCause & avsWriteData[CAUSE_SW_BIT];
    wire sysResetReq = ~extResetSyncN | wdtTimeout | swForce | badClear;

    // ========================================================
    // Reset cause flags
    // ========================================================
    // Flags survive every reset except power-on, which is reset itself
    // pin sets no flag, so all zero reads as external
    always_comb begin
        cause_nxt = cause_r;
        // write one to clear; zeros leave flags
        if (wrCauseClr) begin
            cause_nxt = cause_nxt & ~clrBits;
        end
        // watchdog sets bit 1, winning over a clear
        if (wdtTimeout) begin
            cause_nxt[CAUSE_WDT_BIT] = 1'b1;
        end
        // software bit stays set as the cause
        if (swForce) begin
            cause_nxt[CAUSE_SW_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cause_r <= CAUSE_RESET;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // ========================================================
    // Map select
    // ========================================================
    // any reset restores program memory at zero
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mapSram_r <= 1'b0;
        end else if (sysResetReq | (boot_r == BOOT_HOLD)) begin
            mapSram_r <= 1'b0;
        end else if (wrMap) begin
            // set mirrors SRAM; clear restores program memory
            mapSram_r <= avsWriteData[MAP_SRAM_BIT];
        end
    end

    // ========================================================
    // Boot sequencer
    // ========================================================
    logic [15:0] bootCnt_r;
    logic [15:0] bootCnt_nxt;
    wire cntDone = (bootCnt_r == 16'h0);

    always_comb begin
        boot_nxt = boot_r;
        bootCnt_nxt = cntDone ? 16'h0 : bootCnt_r - 16'h1;
        case (boot_r)
            BOOT_HOLD: begin
                if (cntDone) begin
                    boot_nxt = BOOT_KERNEL;
                    bootCnt_nxt = 16'(BOOT_CYCLES - 1);
                end
            end
            // factory routine, then jump to zero when boot mode high
            BOOT_KERNEL: begin
                if (cntDone) begin
                    boot_nxt = bootModeSync ? BOOT_RUN : BOOT_LOADER;
                end
            end
            BOOT_RUN: begin
            end
            BOOT_LOADER: begin
            end
            default: begin
                boot_nxt = BOOT_HOLD;
            end
        endcase
        if (sysResetReq) begin
            boot_nxt = BOOT_HOLD;
            bootCnt_nxt = 16'(HOLD_CYCLES - 1);
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            boot_r <= BOOT_HOLD;
            bootCnt_r <= 16'(RST_HOLD_CYCLES - 1);
        end else begin
            boot_r <= boot_nxt;
            bootCnt_r <= bootCnt_nxt;
        end
    end

    wire bootJump = (boot_r == BOOT_KERNEL) & (boot_nxt == BOOT_RUN);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            coreResetOut <= 1'b1;
            kernelMode <= 1'b0;
            bootVector <= KERNEL_BASE;
        end else begin
            coreResetOut <= (boot_nxt == BOOT_HOLD);
            kernelMode <= (boot_nxt == BOOT_KERNEL) | (boot_nxt == BOOT_LOADER);
            // user reset vector is address zero
            bootVector <= (boot_nxt == BOOT_RUN) ? VEC_BASE : KERNEL_BASE;
        end
    end

    // ========================================================
    // Address remap
    // ========================================================
    // vector area at the bottom
    wire inVector = (cpuAddr <= VEC_TOP);
    wire inMirror = (cpuAddr < MIRROR_SIZE);
    // factory region reachable only in kernel mode
    wire inKernel = (cpuAddr >= KERNEL_BASE) & (cpuAddr < KERNEL_BASE + KERNEL_SIZE);
    wire hidden = inKernel & ~kernelMode;
    wire toSram = inMirror & mapSram_r;
    wire [31:0] mirrorBase = mapSram_r ? SRAM_BASE : FLASH_BASE;
    // code above the window is never redirected by the mirror
    wire [31:0] remapped = inMirror ? (mirrorBase | cpuAddr) : cpuAddr;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            memReq <= 1'b0;
            memAddr <= 32'h0;
            memSelSram <= 1'b0;
            memDenied <= 1'b0;
            memVector <= 1'b0;
        end else begin
            memReq <= cpuReq & ~hidden & ~coreResetOut;
            memDenied <= cpuReq & hidden;
            if (cpuReq) begin
                memAddr <= hidden ? 32'h0 : remapped;
                memSelSram <= toSram;
                memVector <= inVector;
            end
        end
    end

    // ========================================================
    // Interrupts
    // ========================================================
    // Status, enable and clear share one bit layout
    wire [2:0] irqEvents = {bootJump, badClear, cpuReq & hidden};

    always_comb begin
        irqStat_nxt = irqStat_r;
        if (wrIrqClr) begin
            irqStat_nxt = irqStat_nxt & ~clrBits;
        end
        // Event wins over a clear in the same cycle
        irqStat_nxt = irqStat_nxt | irqEvents;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irqStat_r <= IRQ_RESET;
            irqEn_r <= IRQ_RESET;
        end else begin
            irqStat_r <= irqStat_nxt;
            if (wrIrqEn) begin
                irqEn_r <= avsWriteData[2:0];
            end
        end
    end

    // Level output, held until software clears the status
    assign irqOut = |(irqStat_r & irqEn_r);

endmodule

// [testbench/rcbr_assertions.sv]
// Checker for the reset-cause and boot-remap top ports.
// Assumes one core_clk domain and the async high reset.
`timescale 1ns/1ps
module rcbr_assertions
    import rcbr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Bus
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic avsWaitRequest,
    // Core side
    input wire logic coreResetOut,
    input wire logic kernelMode,
    input wire logic [31:0] bootVector,
    input wire logic cpuReq,
    input wire logic [31:0] cpuAddr,
    input wire logic memReq,
    input wire logic [31:0] memAddr,
    input wire logic memSelSram,
    input wire logic memDenied,
    input wire logic memVector
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire takeReq = cpuReq && !coreResetOut;
    wire hiddenAddr = cpuAddr >= KERNEL_BASE && cpuAddr < KERNEL_BASE + KERNEL_SIZE;
    // ========================================================
    // Properties
    a_vector_flag: assert property (takeReq && cpuAddr <= VEC_TOP |=> memVector)
        else $error("vector flag missing");
    a_sram_base: assert property (memReq && memSelSram |-> memAddr[31:11] == SRAM_BASE[31:11])
        else $error("sram mirror base wrong");
    a_flash_base: assert property (memReq && memVector && !memSelSram |->
        memAddr[31:11] == FLASH_BASE[31:11])
        else $error("flash mirror base wrong");
    a_hidden_deny: assert property (takeReq && hiddenAddr && !kernelMode |=> memDenied && !memReq)
        else $error("hidden region reached");
    a_boot_kernel: assert property ($fell(coreResetOut) |-> kernelMode [*3])
        else $error("factory routine skipped");
    a_kernel_vector: assert property (kernelMode |-> bootVector == KERNEL_BASE)
        else $error("boot vector wrong in kernel");
    a_por_hold: assert property ($fell(reset) |-> coreResetOut && !kernelMode)
        else $error("core not held after reset");
    a_bus_wait: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
        else $error("wait state not one cycle");
    c_boot_done: cover property ($fell(kernelMode));
    c_denied: cover property (memDenied);
    c_sram_hit: cover property (memReq && memSelSram);
endmodule
bind rcbr_top rcbr_assertions u_chk (.core_clk(core_clk), .reset(reset), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWaitRequest(avsWaitRequest), .coreResetOut(coreResetOut),
    .kernelMode(kernelMode), .bootVector(bootVector), .cpuReq(cpuReq), .cpuAddr(cpuAddr),
    .memReq(memReq), .memAddr(memAddr), .memSelSram(memSelSram), .memDenied(memDenied),
    .memVector(memVector));

// [testbench/rcbr_core_model.sv]
// Core model issuing single fetches through the remap port.
// Assumes the bench raises fetchGo for one cycle per fetch.
`timescale 1ns/1ps
module rcbr_core_model (
    // Clock and core reset
    input wire logic core_clk,
    input wire logic coreResetOut,
    // Bench command
    input wire logic fetchGo,
    input wire logic [31:0] fetchAddr,
    // Fetch port
    output logic cpuReq,
    output logic [31:0] cpuAddr
);
    initial cpuAddr = 32'h0008_0024;
    // Idle address toggles so no stale value can match
    always @(posedge core_clk) begin
        cpuReq <= fetchGo && !coreResetOut;
        cpuAddr <= fetchGo ? fetchAddr : ~cpuAddr;
    end
endmodule

// [testbench/reset_cause_and_boot_remap_tb_top.sv]
// Bench for the reset-cause and boot-remap block.
// Assumes short hold and boot counts set through parameters.
`timescale 1ns/1ps
module reset_cause_and_boot_remap_tb_top import rcbr_pkg::*;;
    typedef struct packed {
        logic [31:0] addr;
        logic map;
        logic [31:0] expAddr;
        logic [2:0] flags;
    } rcbr_row_t;
    logic core_clk = 1'h0;
    logic reset = 1'h1;
    logic extResetPinN = 1'h1, bootModePin = 1'h1, wdtTimeout = 1'h0, fetchGo = 1'h0;
    logic [7:0] avsAddress = 8'h0;
    logic avsRead = 1'h0, avsWrite = 1'h0;
    logic [31:0] avsWriteData = 32'h0, fetchAddr = 32'h0, rd;
    logic [3:0] avsByteEnable = 4'hF;
    logic [31:0] avsReadData, bootVector, cpuAddr, memAddr;
    logic avsWaitRequest, coreResetOut, kernelMode, cpuReq, memReq;
    logic memSelSram, memDenied, memVector, irqOut;
    int err_count = 0, check_count = 0;
    rcbr_top #(.HOLD_CYCLES(2), .BOOT_CYCLES(4)) dut (.core_clk(core_clk), .reset(reset),
        .extResetPinN(extResetPinN), .bootModePin(bootModePin), .wdtTimeout(wdtTimeout),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .coreResetOut(coreResetOut), .kernelMode(kernelMode),
        .bootVector(bootVector), .cpuReq(cpuReq), .cpuAddr(cpuAddr), .memReq(memReq),
        .memAddr(memAddr), .memSelSram(memSelSram), .memDenied(memDenied),
        .memVector(memVector), .irqOut(irqOut));
    rcbr_core_model core (.core_clk(core_clk), .coreResetOut(coreResetOut), .fetchGo(fetchGo),
        .fetchAddr(fetchAddr), .cpuReq(cpuReq), .cpuAddr(cpuAddr));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    // ========================================================
    // Tasks
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n = 0;
        @(posedge core_clk);
        avsAddress <= a;
        avsWriteData <= d;
        avsByteEnable <= be;
        avsWrite <= wr;
        avsRead <= !wr;
        #1;
        while (avsWaitRequest !== 1'h0) begin
            @(posedge core_clk);
            #1;
            n++;
            if (n > 20) begin
                err_count++;
                end_of_test();
            end
        end
        @(posedge core_clk);
        avsWrite <= 1'h0;
        avsRead <= 1'h0;
        rd = avsReadData;
        #1;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(1'h0, a, 32'h0, 4'hF);
        check(what, rd, exp);
    endtask
    // Wait for core held in reset, or for user code running
    task automatic waitFor(input logic held);
        int n = 0;
        while ((held ? coreResetOut !== 1'h1 : (coreResetOut | kernelMode) !== 1'h0)) begin
            @(posedge core_clk);
            #1;
            n++;
            if (n > 200) begin
                err_count++;
                end_of_test();
            end
        end
    endtask
    task automatic fetch(input rcbr_row_t r);
        @(posedge core_clk);
        fetchGo <= 1'h1;
        fetchAddr <= r.addr;
        @(posedge core_clk);
        fetchGo <= 1'h0;
        @(posedge core_clk);
        #1;
        check("memAddr", memAddr, r.expAddr);
        check("memFlags", {29'h0, memDenied, memSelSram, memVector}, {29'h0, r.flags});
        check("memReq", {31'h0, memReq}, {31'h0, !r.flags[2]});
    endtask
    // ========================================================
    // Sequence
    initial begin
        rcbr_row_t rows [8];
        rows = '{'{32'h10, 1'h0, 32'h0008_0010, 3'h1}, '{32'h20, 1'h0, 32'h0008_0020, 3'h1},
            '{32'h24, 1'h0, 32'h0008_0024, 3'h0}, '{32'h7FC, 1'h1, 32'h0001_07FC, 3'h2},
            '{32'h0, 1'h1, 32'h0001_0000, 3'h3}, '{32'h800, 1'h1, 32'h0000_0800, 3'h0},
            '{32'h0009_F800, 1'h0, 32'h0, 3'h4}, '{32'h0009_FFFC, 1'h1, 32'h0, 3'h4}};
        repeat (2) @(posedge core_clk);
        reset <= 1'h0;
        waitFor(1'h0);
        check("bootVector", bootVector, 32'h0);
        rdChk(OFS_CAUSE, 32'h1, "cause");
        rdChk(OFS_MAP_SEL, 32'h0, "mapSel");
        rdChk(OFS_BOOT_STAT, 32'h6, "bootStat");
        rdChk(8'h40, 32'h0, "unmapped");
        $display("Test reset done");
        foreach (rows[i]) begin
            // remap while core runs above window
            bus(1'h1, OFS_MAP_SEL, {31'h0, rows[i].map}, 4'h1);
            fetch(rows[i]);
        end
        $display("Test mirror table done");
        bus(1'h1, OFS_MAP_SEL, 32'h0, 4'hE);
        rdChk(OFS_MAP_SEL, 32'h1, "mapSel");
        rdChk(OFS_IRQ_STAT, 32'h5, "irqStat");
        bus(1'h1, OFS_IRQ_EN, 32'h4, 4'h1);
        check("irqOut", {31'h0, irqOut}, 32'h1);
        bus(1'h1, OFS_IRQ_EN, 32'h1, 4'h1);
        check("irqOut", {31'h0, irqOut}, 32'h1);
        bus(1'h1, OFS_IRQ_CLR, 32'h1, 4'h1);
        check("irqOut", {31'h0, irqOut}, 32'h0);
        rdChk(OFS_IRQ_STAT, 32'h4, "irqStat");
        $display("Test irq done");
        @(posedge core_clk);
        wdtTimeout <= 1'h1;
        @(posedge core_clk);
        wdtTimeout <= 1'h0;
        waitFor(1'h1);
        waitFor(1'h0);
        rdChk(OFS_CAUSE, 32'h3, "cause");
        rdChk(OFS_MAP_SEL, 32'h0, "mapSel");
        bus(1'h1, OFS_CAUSE_CLR, 32'h1, 4'h1);
        waitFor(1'h1);
        waitFor(1'h0);
        rdChk(OFS_CAUSE, 32'h2, "cause");
        rdChk(OFS_IRQ_STAT, 32'h6, "irqStat");
        bus(1'h1, OFS_CAUSE_CLR, 32'hFA, 4'h1);
        rdChk(OFS_CAUSE, 32'h0, "cause");
        check("heldAfterClr", {30'h0, coreResetOut, kernelMode}, 32'h0);
        $display("Test watchdog and clear done");
        // Boot mode low: software reset ends in the loader
        @(posedge core_clk);
        bootModePin <= 1'h0;
        bus(1'h1, OFS_CAUSE, 32'h4, 4'h1);
        waitFor(1'h1);
        repeat (12) @(posedge core_clk);
        rdChk(OFS_BOOT_STAT, 32'h3, "bootStat");
        check("loaderVec", bootVector, KERNEL_BASE);
        check("loaderMode", {31'h0, kernelMode}, 32'h1);
        rdChk(OFS_CAUSE, 32'h4, "cause");
        bus(1'h1, OFS_CAUSE_CLR, 32'h4, 4'h1);
        bus(1'h1, OFS_MAP_SEL, 32'h1, 4'h1);
        @(posedge core_clk);
        bootModePin <= 1'h1;
        extResetPinN <= 1'h0;
        waitFor(1'h1);
        @(posedge core_clk);
        extResetPinN <= 1'h1;
        waitFor(1'h0);
        check("bootVector", bootVector, 32'h0);
        rdChk(OFS_CAUSE, 32'h0, "cause");
        rdChk(OFS_MAP_SEL, 32'h0, "mapSel");
        $display("Test software and pin reset done");
        // Power-on reset again in mid-run
        bus(1'h1, OFS_MAP_SEL, 32'h1, 4'h1);
        @(posedge core_clk);
        reset <= 1'h1;
        repeat (2) @(posedge core_clk);
        reset <= 1'h0;
        waitFor(1'h0);
        rdChk(OFS_CAUSE, 32'h1, "cause");
        rdChk(OFS_MAP_SEL, 32'h0, "mapSel");
        rdChk(OFS_IRQ_STAT, 32'h4, "irqStat");
        $display("Test power-on reset done");
        end_of_test();
    end
endmodule
